/* File: rtl/fp_est_pkg.sv */
// constants and types shared by the estimate and convert slice
package fp_est_pkg;
    localparam logic [15:0] OPC_RECIP   = 16'he693;
    localparam logic [15:0] OPC_RSQRT   = 16'he692;
    localparam logic [15:0] OPC_TO_I16  = 16'he68c;
    localparam int          ROUND_BIT   = 15;
    localparam int          SRC_LSB     = 3;
    localparam int          DST_LSB     = 0;
    localparam int          NUM_REGS    = 8;
    localparam logic [31:0] FP_REG_RST  = 32'h0000_0000;
    localparam logic [31:0] FP_MAX_POS  = 32'h7f7f_ffff;
    localparam logic [31:0] FP_MIN_NORM = 32'h0080_0000;
    localparam logic [7:0]  EXP_BIAS    = 8'h7f;
    localparam logic [15:0] I16_MAX     = 16'h7fff;
    localparam logic [15:0] I16_MIN     = 16'h8000;

    typedef enum logic [1:0] {
        OP_RECIP = 2'b00,
        OP_RSQRT = 2'b01,
        OP_TRUNC = 2'b10,
        OP_ROUND = 2'b11
    } op_type;
endpackage

/* File: rtl/fp_issue_if.sv */
// issue bundle between decode and the execution unit
`timescale 1ns/1ps
interface fp_issue_if;
    logic         valid;
    fp_est_pkg::op_type op;
    logic [31:0]  src;
    logic [2:0]   dst;
    logic         done;
    logic [31:0]  result;
    logic [2:0]   res_dst;
    logic         uf;
    logic         of;
    modport issuer (output valid, op, src, dst, input done, result, res_dst, uf, of);
    modport unit   (input valid, op, src, dst, output done, result, res_dst, uf, of);
endinterface

/* File: rtl/fp_est_unit.sv */
// second pipeline stage: estimate and conversion arithmetic
`timescale 1ns/1ps
module fp_est_unit
    import fp_est_pkg::*;
(
    input  wire logic   clk,
    input  wire logic   rst,
    fp_issue_if.unit    iss
);
    typedef struct packed {
        logic        done;
        logic [31:0] result;
        logic [2:0]  res_dst;
        logic        uf;
        logic        of;
    } st_type;

    st_type st_reg;
    st_type st_next;

    // saturating float to signed 16 bit, optional round-half-even
    function automatic logic [15:0] to_i16(input logic [31:0] f, input logic rnd);
        logic [7:0]  e;
        logic [47:0] m;
        logic [23:0] ip;
        logic        g;
        logic        s;
        logic [24:0] mag;
        int          sh;
        e = f[30:23];
        m = {24'h0, (e != 8'h00), f[22:0]};
        to_i16 = 16'h0000;
        if (e == 8'hff && f[22:0] != 23'h0) begin
            to_i16 = I16_MAX;
        end else if (e >= 8'h8e) begin
            to_i16 = f[31] ? I16_MIN : I16_MAX;
        end else if (e >= 8'h7e) begin
            sh = 150 - int'(e);
            m  = m << (24 - sh);
            ip = m[47:24];
            g  = m[23];
            s  = |m[22:0];
            mag = {1'b0, ip};
            if (rnd && g && (s || ip[0]))
                mag = mag + 25'd1;
            if (!f[31] && mag > 25'h7fff)
                to_i16 = I16_MAX;
            else if (f[31] && mag > 25'h8000)
                to_i16 = I16_MIN;
            else
                to_i16 = f[31] ? 16'(-mag[15:0]) : mag[15:0];
        end
    endfunction

    // bitwise integer square root, one result bit per step
    function automatic logic [12:0] isqrt26(input logic [25:0] n);
        logic [12:0] r;
        logic [12:0] c;
        logic [25:0] sq;
        r = 13'h0;
        for (int i = 12; i >= 0; i--) begin
            c  = r | (13'h1 << i);
            sq = {13'h0, c} * {13'h0, c};
            if (sq <= n)
                r = c;
        end
        return r;
    endfunction

    // 12-bit divide keeps the seed well inside eight bits; wider would only cost area
    function automatic logic [13:0] recip_seed(input logic [11:0] f);
        logic [25:0] q;
        q = 26'h200_0000 / {13'h0, 1'b1, f};
        return q[13:0];
    endfunction

    always_comb begin
        logic [7:0]  e;
        logic [8:0]  ne;
        logic [13:0] rq;
        logic [12:0] s;
        logic [25:0] n;
        logic [15:0] q;
        e  = iss.src[30:23];
        ne = 9'h0;
        rq = 14'h0;
        s  = 13'h0;
        n  = 26'h0;
        q  = 16'h0;
        st_next = '0;
        st_next.done    = iss.valid;
        st_next.res_dst = iss.dst;
        if (iss.valid) begin
            unique case (iss.op)
                OP_RECIP: begin
                    rq = recip_seed(iss.src[22:11]);
                    if (e == 8'h00) begin
                        st_next.result = {1'b0, FP_MAX_POS[30:0]};
                        st_next.of = 1'b1;
                    end else if (e >= 8'hfd) begin
                        // result would be denormal or zero: clamp to smallest normal, sign kept
                        st_next.result = {iss.src[31], FP_MIN_NORM[30:0]};
                        st_next.uf = 1'b1;
                    end else begin
                        ne = 9'd253 - {1'b0, e} + {8'h0, rq[13]};
                        st_next.result = {iss.src[31], ne[7:0], rq[11:0], 11'h0};
                    end
                end
                OP_RSQRT: begin
                    if (e == 8'h00 || iss.src[31]) begin
                        st_next.result = FP_MAX_POS;
                        st_next.of = 1'b1;
                    end else if (e == 8'hff) begin
                        st_next.result = FP_MIN_NORM;
                        st_next.uf = 1'b1;
                    end else begin
                        // odd exponent roots the mantissa, even roots twice it: one octave either way
                        n  = e[0] ? {2'b01, iss.src[22:0], 1'b0} : {1'b1, iss.src[22:0], 2'b00};
                        s  = isqrt26(n);
                        rq = recip_seed(s[11:0]);
                        ne = 9'd380 - {1'b0, e};
                        st_next.result = {1'b0, 8'(ne[8:1] + {7'h0, rq[13]}), rq[11:0], 11'h0};
                    end
                end
                OP_TRUNC, OP_ROUND: begin
                    q = to_i16(iss.src, iss.op == OP_ROUND);
                    st_next.result = {{16{q[15]}}, q};
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign iss.done    = st_reg.done;
    assign iss.result  = st_reg.result;
    assign iss.res_dst = st_reg.res_dst;
    assign iss.uf      = st_reg.uf;
    assign iss.of      = st_reg.of;

    a_conv_flags: assert property (@(posedge clk) disable iff (rst)
        iss.valid && iss.op[1] |=> !iss.uf && !iss.of) else $error("convert raised a flag");
    a_conv_signext: assert property (@(posedge clk) disable iff (rst)
        $past(iss.valid && iss.op[1]) |-> iss.result[31:16] == {16{iss.result[15]}}) else $error("no sign extension");
    a_est_nonan: assert property (@(posedge clk) disable iff (rst)
        $past(iss.valid && !iss.op[1]) |-> iss.result[30:23] != 8'hff && iss.result[30:23] != 8'h00)
        else $error("estimate gave nan, zero or denormal");
endmodule

/* File: rtl/fp_estimate_and_int16_convert.sv */
// estimate and short convert slice with its register file and status flags
`timescale 1ns/1ps
module fp_estimate_and_int16_convert
    import fp_est_pkg::*;
(
    input  wire logic        CLOCK,
    input  wire logic        SYS_RST,
    input  wire logic        INSTR_VALID,
    input  wire logic [15:0] INSTR_LSW,
    input  wire logic [15:0] INSTR_MSW,
    input  wire logic        LOAD_VALID,
    input  wire logic [2:0]  LOAD_IDX,
    input  wire logic [31:0] LOAD_DATA,
    input  wire logic [2:0]  READ_IDX,
    input  wire logic        FLAG_CLEAR,
    output logic [31:0]      READ_DATA,
    output logic             OP_ACCEPTED,
    output logic             OP_DONE,
    output logic             LATCHED_UNDERFLOW_FLAG,
    output logic             LATCHED_OVERFLOW_FLAG
);
    typedef struct packed {
        logic [NUM_REGS-1:0][31:0] fp_reg;
        logic [31:0]               read_data;
        logic                      accepted;
        logic                      done;
        logic                      latched_underflow_flag;
        logic                      latched_overflow_flag;
    } st_type;

    st_type st_reg;
    st_type st_next;

    fp_issue_if iss();

    fp_est_unit u_unit (
        .clk (CLOCK),
        .rst (SYS_RST),
        .iss (iss.unit)
    );

    function automatic logic is_recip(input logic [15:0] lsw);
        is_recip = (lsw == OPC_RECIP);
    endfunction

    function automatic logic is_rsqrt(input logic [15:0] lsw);
        is_rsqrt = (lsw == OPC_RSQRT);
    endfunction

    function automatic logic is_conv(input logic [15:0] lsw);
        is_conv = (lsw == OPC_TO_I16);
    endfunction

    logic        dec_ok;
    logic [2:0]  src_idx;

    always_comb begin
        src_idx   = INSTR_MSW[SRC_LSB +: 3];
        dec_ok    = INSTR_VALID && (is_recip(INSTR_LSW) || is_rsqrt(INSTR_LSW) || is_conv(INSTR_LSW));
        iss.valid = dec_ok;
        iss.src   = st_reg.fp_reg[src_idx];
        iss.dst   = INSTR_MSW[DST_LSB +: 3];
        if (is_recip(INSTR_LSW))
            iss.op = OP_RECIP;
        else if (is_rsqrt(INSTR_LSW))
            iss.op = OP_RSQRT;
        else if (INSTR_MSW[ROUND_BIT])
            iss.op = OP_ROUND;
        else
            iss.op = OP_TRUNC;
    end

    // result written two cycles after issue; the delay-slot instruction
    // must not use that register, so no forwarding is built
    always_comb begin
        st_next = st_reg;
        st_next.accepted = dec_ok;
        st_next.done     = iss.done;
        if (LOAD_VALID)
            st_next.fp_reg[LOAD_IDX] = LOAD_DATA;
        if (iss.done)
            st_next.fp_reg[iss.res_dst] = iss.result;
        if (FLAG_CLEAR) begin
            st_next.latched_underflow_flag = 1'b0;
            st_next.latched_overflow_flag = 1'b0;
        end
        // set beats a clear in the same cycle
        if (iss.done && iss.uf)
            st_next.latched_underflow_flag = 1'b1;
        if (iss.done && iss.of)
            st_next.latched_overflow_flag = 1'b1;
        st_next.read_data = st_next.fp_reg[READ_IDX];
    end

    always_ff @(posedge CLOCK) begin
        if (SYS_RST) begin
            st_reg <= '0;
            for (int i = 0; i < NUM_REGS; i++)
                st_reg.fp_reg[i] <= FP_REG_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign READ_DATA              = st_reg.read_data;
    assign OP_ACCEPTED            = st_reg.accepted;
    assign OP_DONE                = st_reg.done;
    assign LATCHED_UNDERFLOW_FLAG = st_reg.latched_underflow_flag;
    assign LATCHED_OVERFLOW_FLAG  = st_reg.latched_overflow_flag;

    a_two_cycle_done: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        dec_ok |=> ##1 OP_DONE) else $error("op did not complete in two cycles");
    a_recip_decode: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        INSTR_VALID && INSTR_LSW == 16'he693 |-> iss.op == OP_RECIP) else $error("recip not decoded");
    a_rsqrt_decode: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        INSTR_VALID && INSTR_LSW == 16'he692 |-> iss.op == OP_RSQRT) else $error("rsqrt not decoded");
    a_round_decode: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        INSTR_VALID && INSTR_LSW == 16'he68c |-> iss.op == (INSTR_MSW[15] ? OP_ROUND : OP_TRUNC))
        else $error("convert variant wrong");
    a_flag_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        LATCHED_UNDERFLOW_FLAG && !FLAG_CLEAR |=> LATCHED_UNDERFLOW_FLAG) else $error("underflow flag dropped");
    a_of_sticky: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        LATCHED_OVERFLOW_FLAG && !FLAG_CLEAR |=> LATCHED_OVERFLOW_FLAG) else $error("overflow flag dropped");
    a_dest_written: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        dec_ok && !LOAD_VALID ##1 !LOAD_VALID |=> st_reg.fp_reg[$past(iss.dst, 2)] == $past(iss.result))
        else $error("destination not updated");
    a_conv_noflag: assert property (@(posedge CLOCK) disable iff (SYS_RST)
        dec_ok && iss.op[1] ##1 !FLAG_CLEAR |=> $stable(LATCHED_OVERFLOW_FLAG) && $stable(LATCHED_UNDERFLOW_FLAG))
        else $error("convert changed flags");

    c_recip:  cover property (@(posedge CLOCK) dec_ok && iss.op == OP_RECIP);
    c_rsqrt:  cover property (@(posedge CLOCK) dec_ok && iss.op == OP_RSQRT);
    c_round:  cover property (@(posedge CLOCK) dec_ok && iss.op == OP_ROUND);
    c_of_set: cover property (@(posedge CLOCK) $rose(LATCHED_OVERFLOW_FLAG));
endmodule

/* File: testbench/host_issue_model.sv */
// host decode model that issues instructions and register loads
`timescale 1ns/1ps
module host_issue_model (
    input  wire logic        clk,
    output logic             instr_valid,
    output logic [15:0]      instr_lsw,
    output logic [15:0]      instr_msw,
    output logic             load_valid,
    output logic [2:0]       load_idx,
    output logic [31:0]      load_data
);
    logic       slot_busy;
    logic [2:0] slot_dst;

    initial begin
        instr_valid = 1'b0;
        instr_lsw   = 16'h0000;
        instr_msw   = 16'h0000;
        load_valid  = 1'b0;
        load_idx    = 3'h0;
        load_data   = 32'h00000000;
        slot_busy   = 1'b0;
        slot_dst    = 3'h0;
    end

    // callers sit just after a falling edge; one write held over one rising edge,
    // then one idle edge so a following load never re-raises the strobe in the same step
    task automatic load(input logic [2:0] idx, input logic [31:0] data);
        load_valid = 1'b1;
        load_idx   = idx;
        load_data  = data;
        @(negedge clk);
        load_valid = 1'b0;
        load_data  = ~data;
        @(negedge clk);
    endtask

    task automatic issue(input logic [15:0] lsw, input logic [15:0] msw);
        // no interlock in the unit, so the host stalls instead of touching the slot's target
        if (slot_busy && (msw[5:3] == slot_dst || msw[2:0] == slot_dst)) begin
            instr_valid = 1'b0;
            @(negedge clk);
        end
        instr_valid = 1'b1;
        instr_lsw   = lsw;
        instr_msw   = msw;
        slot_busy   = 1'b1;
        slot_dst    = msw[2:0];
    endtask

    // released words are inverted so a stale value never looks valid
    task automatic idle();
        instr_valid = 1'b0;
        instr_lsw   = ~instr_lsw;
        instr_msw   = ~instr_msw;
        slot_busy   = 1'b0;
    endtask
endmodule

/* File: testbench/test_fp_estimate_and_int16_convert.sv */
// self-checking bench for the estimate and short convert slice
`timescale 1ns/1ps
module test_fp_estimate_and_int16_convert;
    import fp_est_pkg::*;
    logic        clock;
    logic        sys_rst;
    logic        instr_valid;
    logic [15:0] instr_lsw;
    logic [15:0] instr_msw;
    logic        load_valid;
    logic [2:0]  load_idx;
    logic [31:0] load_data;
    logic [2:0]  read_idx;
    logic        flag_clear;
    logic [31:0] read_data;
    logic        op_accepted;
    logic        op_done;
    logic        uf_flag;
    logic        of_flag;
    int          error_cnt;
    int          n_checks;
    logic [31:0] cv_src [12] = '{32'h40a00000, 32'hc0a00000, 32'h3fd9999a, 32'h3fd9999a, 32'hbfd9999a,
        32'h40200000, 32'h40600000, 32'hc0200000, 32'h48927c00, 32'hc8927c00, 32'h7fc00000, 32'hbfd9999a};
    logic [31:0] cv_exp [12] = '{32'h00000005, 32'hfffffffb, 32'h00000001, 32'h00000002, 32'hfffffffe,
        32'h00000002, 32'h00000004, 32'hfffffffe, 32'h00007fff, 32'hffff8000, 32'h00007fff, 32'hffffffff};
    logic [11:0] cv_rnd = 12'b001011111000;
    logic [31:0] es_src [10] = '{32'h40000000, 32'h40400000, 32'hc0800000, 32'h40800000, 32'h40000000,
        32'h00000000, 32'hff800000, 32'hbf800000, 32'h7f800000, 32'h00000001};
    logic [31:0] es_exp [10] = '{32'h3f000000, 32'h3eaaaaab, 32'hbe800000, 32'h3f000000, 32'h3f3504f3,
        FP_MAX_POS, 32'h80800000, FP_MAX_POS, FP_MIN_NORM, FP_MAX_POS};
    logic [9:0]  es_uf    = 10'b1111000000;
    logic [9:0]  es_of    = 10'b1111100000;
    logic [9:0]  es_tol   = 10'b0000011111;
    logic [9:0]  es_recip = 10'b1001100111;

    fp_estimate_and_int16_convert dut (.CLOCK(clock), .SYS_RST(sys_rst), .INSTR_VALID(instr_valid),
        .INSTR_LSW(instr_lsw), .INSTR_MSW(instr_msw), .LOAD_VALID(load_valid), .LOAD_IDX(load_idx),
        .LOAD_DATA(load_data), .READ_IDX(read_idx), .FLAG_CLEAR(flag_clear), .READ_DATA(read_data),
        .OP_ACCEPTED(op_accepted), .OP_DONE(op_done), .LATCHED_UNDERFLOW_FLAG(uf_flag),
        .LATCHED_OVERFLOW_FLAG(of_flag));
    host_issue_model host (.clk(clock), .instr_valid(instr_valid), .instr_lsw(instr_lsw),
        .instr_msw(instr_msw), .load_valid(load_valid), .load_idx(load_idx), .load_data(load_data));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // estimates are only about eight bits good, so accept a band of ulps around the exact value
    function automatic logic [31:0] near(input logic [31:0] a, input logic [31:0] e, input logic [31:0] tol);
        logic [31:0] d;
        d = (a > e) ? a - e : e - a;
        return (d <= tol) ? e : a;
    endfunction

    task automatic read_chk(input logic [2:0] idx, input logic [31:0] e);
        read_idx = idx;
        @(negedge clock);
        check(read_data, e);
    endtask

    task automatic run_op(input logic [15:0] lsw, input logic [15:0] msw, input logic [31:0] v,
                          input logic [31:0] e, input logic [31:0] tol, input logic euf, input logic eof);
        read_idx = msw[2:0];
        host.load(msw[2:0], 32'h12345678);
        host.load(msw[5:3], v);
        host.issue(lsw, msw);
        @(negedge clock);
        host.idle();
        check({30'h0, op_accepted, op_done}, 32'h2);
        check(read_data, 32'h12345678);
        @(negedge clock);
        check({31'h0, op_done}, 32'h1);
        check(near(read_data, e, tol), e);
        check({30'h0, uf_flag, of_flag}, {30'h0, euf, eof});
    endtask

    task automatic t_reset();
        for (int i = 0; i < NUM_REGS; i++) read_chk(3'(i), FP_REG_RST);
        check({30'h0, uf_flag, of_flag}, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_estimate();
        logic [15:0] w;
        for (int i = 0; i < 10; i++) begin
            w = {10'h0, 3'(i % 8), 3'((i + 5) % 8)};
            run_op(es_recip[i] ? OPC_RECIP : OPC_RSQRT, w, es_src[i], es_exp[i],
                   es_tol[i] ? 32'h10000 : 32'h0, es_uf[i], es_of[i]);
        end
        run_op(OPC_TO_I16, 16'h0011, 32'h40a00000, 32'h5, 32'h0, 1'b1, 1'b1);
        flag_clear = 1'b1;
        @(negedge clock);
        flag_clear = 1'b0;
        check({30'h0, uf_flag, of_flag}, 32'h0);
        $display("test estimate done");
    endtask

    task automatic t_convert();
        logic [15:0] w;
        for (int i = 0; i < 12; i++) begin
            w = {cv_rnd[i], 9'h0, 3'(i % 8), 3'((i + 3) % 8)};
            run_op(OPC_TO_I16, w, cv_src[i], cv_exp[i], 32'h0, 1'b0, 1'b0);
        end
        $display("test convert done");
    endtask

    task automatic t_ignore();
        read_idx = 3'h4;
        host.load(3'h4, 32'hcafe0004);
        host.issue(16'he694, 16'h0004);
        @(negedge clock);
        host.issue(16'he68e, 16'h8015);
        @(negedge clock);
        host.idle();
        repeat (3) begin
            check({30'h0, op_accepted, op_done}, 32'h0);
            @(negedge clock);
        end
        check(read_data, 32'hcafe0004);
        $display("test ignore done");
    endtask

    task automatic t_b2b();
        host.load(3'h1, 32'h40a00000);
        host.load(3'h2, 32'hc0200000);
        host.issue(OPC_TO_I16, 16'h000d);
        @(negedge clock);
        host.issue(OPC_TO_I16, 16'h8016);
        @(negedge clock);
        host.idle();
        check({30'h0, op_accepted, op_done}, 32'h3);
        @(negedge clock);
        check({30'h0, op_accepted, op_done}, 32'h1);
        read_chk(3'h5, 32'h00000005);
        read_chk(3'h6, 32'hfffffffe);
        $display("test back to back done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // the sequence needs under two hundred cycles; this leaves a wide margin
    initial begin
        repeat (3000) @(posedge clock);
        error_cnt++;
        end_of_test();
    end

    initial begin
        error_cnt  = 0;
        n_checks   = 0;
        sys_rst    = 1'b1;
        read_idx   = 3'h0;
        flag_clear = 1'b0;
        repeat (3) @(negedge clock);
        sys_rst = 1'b0;
        t_reset();
        t_estimate();
        t_convert();
        t_ignore();
        t_b2b();
        end_of_test();
    end
endmodule
